// file: core/cci_channel_interp.sv
// Channel selection and serial command interpreter, top level
`timescale 1ns/1ns
module cci_channel_interp import cci_pkg::*; #(
  parameter int unsigned BIT_CYC = cci_pkg::BIT_CYC
) (
  input  wire logic  core_clk,              // System clock
  input  wire logic  arst_n,                // Async reset, active low
  input  wire logic  ce,                    // Clock enable
  input  wire logic  chan_sel_bit0_prog_in, // Select bit 0 and serial in
  input  wire logic  chan_sel_bit1,         // Select bit 1
  input  wire logic  chan_sel_bit2,         // Select bit 2
  input  wire logic  chan_sel_bit3,         // Select bit 3
  output logic [4:0] active_chan,           // Channel in use
  output logic [6:0] tune_index,            // Frequency index tuned
  output logic [18:0] tune_khz,             // Tuned frequency in kHz
  output logic       cmd_mode,              // Command mode unlocked
  output logic       hop_active,            // Temporary tune in force
  output logic       parallel_sel,          // Pins select the channel
  output logic       nv_write               // Nonvolatile store pulse
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] unlock_byte(input logic [4:0] i);
    unlock_byte = UNLOCK_STR[8 * (UNLOCK_LEN - 1 - int'(i)) +: 8];
  endfunction

  function automatic logic is_dig(input logic [7:0] c);
    is_dig = (c >= CH_ZERO) && (c <= CH_NINE);
  endfunction

  function automatic logic [6:0] dec2(input logic [7:0] a,
                                     input logic [7:0] b);
    logic [6:0] t;
    logic [6:0] u;
    t    = 7'(a - CH_ZERO);
    u    = 7'(b - CH_ZERO);
    dec2 = 7'((t << 3) + (t << 1) + u);
  endfunction

  // Upper sixteen entries start one step above the lower ones
  function automatic logic [6:0] factory_idx(input logic [4:0] c);
    logic [6:0] off;
    off = {2'b00, c[3:0], 1'b0};
    factory_idx = (c[4] ? FAC_HI_BASE : FAC_LO_BASE) + off;
  endfunction

  function automatic logic [18:0] to_khz(input logic [6:0] i);
    to_khz = BASE_KHZ + 19'(i * STEP_KHZ);
  endfunction

  // ****************************************************************
  // Receiver
  // ****************************************************************
  cci_char_s rx_char;
  logic      got;
  logic [7:0] ch;
  logic      exec;

  cci_uart_rx #(
    .BIT_CYC (BIT_CYC)
  ) u_rx (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .line_in  (chan_sel_bit0_prog_in),
    .char_out (rx_char)
  );

  assign got  = ce & rx_char.valid;
  assign ch   = rx_char.data;
  assign exec = got & cmd_mode & (ch == CH_CR);

  // ****************************************************************
  // Unlock sequence
  // ****************************************************************
  // Keeps pin bounce in parallel use from reaching the table
  logic [4:0] unlock_cnt_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      unlock_cnt_reg <= 5'h00;
      cmd_mode       <= 1'b0;
    end else if (got) begin
      if (cmd_mode) begin
        if (ch == CH_HASH) begin
          cmd_mode       <= 1'b0;
          unlock_cnt_reg <= 5'h00;
        end
      end else if (ch == unlock_byte(unlock_cnt_reg)) begin
        if (unlock_cnt_reg == 5'(UNLOCK_LEN - 1)) begin
          cmd_mode       <= 1'b1;
          unlock_cnt_reg <= 5'h00;
        end else begin
          unlock_cnt_reg <= unlock_cnt_reg + 5'h01;
        end
      end else begin
        unlock_cnt_reg <= (ch == unlock_byte(5'h00)) ? 5'h01 : 5'h00;
      end
    end
  end

  // ****************************************************************
  // Line buffer
  // ****************************************************************
  logic [7:0] line_reg [LINE_MAX];
  logic [3:0] len_reg;
  logic       ovf_reg;
  logic [8*LINE_MAX-1:0] line_flat;

  // Line feed is dropped so terminals sending CR LF still work
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      len_reg <= 4'h0;
      ovf_reg <= 1'b0;
      for (int i = 0; i < LINE_MAX; i++) line_reg[i] <= 8'h00;
    end else if (got && cmd_mode) begin
      if (ch == CH_CR || ch == CH_SLASH || ch == CH_HASH) begin
        len_reg <= 4'h0;
        ovf_reg <= 1'b0;
      end else if (ch != CH_LF) begin
        if (len_reg == 4'(LINE_MAX)) begin
          ovf_reg <= 1'b1;
        end else begin
          line_reg[len_reg] <= ch;
          len_reg           <= len_reg + 4'h1;
        end
      end
    end
  end

  for (genvar g = 0; g < LINE_MAX; g++) begin : g_flat
    assign line_flat[8*(LINE_MAX-1-g) +: 8] = line_reg[g];
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  cci_cmd_s   cmd;
  logic [47:0] head;
  logic [6:0] n1;
  logic [6:0] m1;
  logic [6:0] m2;

  assign head = line_flat[8*LINE_MAX-1 -: CMD_W];
  assign n1   = dec2(line_reg[7], line_reg[8]);
  assign m1   = dec2(line_reg[5], line_reg[6]);
  assign m2   = dec2(line_reg[8], line_reg[9]);

  always_comb begin
    cmd = '{kind: K_NONE, chan: 5'h00, idx: 7'h00};
    if (ovf_reg) begin
      cmd.kind = K_NONE;
    end else if (len_reg == 4'h9 && line_reg[6] == CH_SP &&
                 is_dig(line_reg[7]) && is_dig(line_reg[8])) begin
      if (head == CMD_GO && n1 <= CHAN_LAST) begin
        cmd.kind = K_GO;
        cmd.chan = n1[4:0];
      end else if (head == CMD_HOP && n1 <= IDX_MAX) begin
        cmd.kind = K_HOP;
        cmd.idx  = n1;
      end
    end else if (len_reg == 4'ha && head[47:16] == CMD_LOAD &&
                 line_reg[4] == CH_SP && line_reg[7] == CH_SP &&
                 is_dig(line_reg[5]) && is_dig(line_reg[6]) &&
                 is_dig(line_reg[8]) && is_dig(line_reg[9]) &&
                 m1 <= CHAN_LAST && m2 <= IDX_MAX) begin
      cmd.kind = K_LOAD;
      cmd.chan = m1[4:0];
      cmd.idx  = m2;
    end else if (len_reg == 4'h6 && head == CMD_PAR) begin
      cmd.kind = K_PAR;
    end else if (len_reg == 4'h6 && head == CMD_SER) begin
      cmd.kind = K_SER;
    end
  end

  // ****************************************************************
  // Channel table
  // ****************************************************************
  // Modelled as flops; a real part would back this with EEPROM
  logic [6:0] table_reg [CHANS];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < CHANS; i++) begin
        table_reg[i] <= factory_idx(5'(i));
      end
    end else if (exec && cmd.kind == K_LOAD) begin
      table_reg[cmd.chan] <= cmd.idx;
    end
  end

  // ****************************************************************
  // Selection mode
  // ****************************************************************
  logic [4:0] ser_chan_reg;
  logic [6:0] hop_idx_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_chan_reg <= SER_CHAN_RST;
      hop_idx_reg  <= 7'h00;
      hop_active   <= 1'b0;
      parallel_sel <= 1'b1;
      nv_write     <= 1'b0;
    end else if (ce) begin
      nv_write <= 1'b0;
      if (exec) begin
        unique case (cmd.kind)
          K_GO: begin
            ser_chan_reg <= cmd.chan;
            parallel_sel <= 1'b0;
            hop_active   <= 1'b0;
            nv_write     <= 1'b1;
          end
          K_HOP: begin
            hop_idx_reg <= cmd.idx;
            hop_active  <= 1'b1;
          end
          K_LOAD: nv_write <= 1'b1;
          K_PAR: begin
            parallel_sel <= 1'b1;
            hop_active   <= 1'b0;
            nv_write     <= 1'b1;
          end
          K_SER: begin
            parallel_sel <= 1'b0;
            hop_active   <= 1'b0;
            nv_write     <= 1'b1;
          end
          K_NONE: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // Tuning outputs
  // ****************************************************************
  // Three-stage pipe: channel, then index, then kHz
  logic [4:0] pin_chan;
  assign pin_chan = {PAR_TOP_BIT, chan_sel_bit3, chan_sel_bit2,
                     chan_sel_bit1, chan_sel_bit0_prog_in};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_chan <= SER_CHAN_RST;
      tune_index  <= factory_idx(SER_CHAN_RST);
      tune_khz    <= to_khz(factory_idx(SER_CHAN_RST));
    end else if (ce) begin
      active_chan <= parallel_sel ? pin_chan : ser_chan_reg;
      tune_index  <= hop_active ? hop_idx_reg
                                : table_reg[active_chan];
      tune_khz    <= to_khz(tune_index);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // While locked nothing on the pin may move the selection state
  locked_exec_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    !cmd_mode |=> $stable(ser_chan_reg) && $stable(parallel_sel)
      && $stable(hop_active))
    else $error("command executed while locked");
  unlock_done_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    got && !cmd_mode && unlock_cnt_reg == 5'(UNLOCK_LEN - 1)
      && ch == unlock_byte(unlock_cnt_reg) |=> cmd_mode)
    else $error("full unlock string did not unlock");
  hash_exit_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    got && cmd_mode && ch == CH_HASH |=> !cmd_mode)
    else $error("hash did not leave command mode");
  par_chan_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    ce && parallel_sel |=> active_chan == $past(pin_chan))
    else $error("parallel channel does not follow pins");
  par_upper_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    ce && parallel_sel |=> active_chan[4])
    else $error("parallel mode reached a lower channel");
  go_store_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    exec && cmd.kind == K_GO |=> ser_chan_reg == $past(cmd.chan)
      && !parallel_sel && !hop_active && nv_write)
    else $error("serial select not applied");
  // A held store pulse would program the nonvolatile table twice
  nv_pulse_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    ce && nv_write |=> !nv_write)
    else $error("store pulse longer than one cycle");
  hop_tune_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    exec && cmd.kind == K_HOP ##1 ce |=>
      tune_index == hop_idx_reg && !nv_write)
    else $error("temporary tune index wrong");
  hop_clear_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    exec && (cmd.kind == K_GO || cmd.kind == K_PAR || cmd.kind == K_SER)
      |=> !hop_active)
    else $error("temporary tune survived a mode command");
  load_entry_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    exec && cmd.kind == K_LOAD |=>
      table_reg[$past(cmd.chan)] == $past(cmd.idx))
    else $error("table entry not written");
  ser_mode_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    exec && cmd.kind == K_SER ##1 ce |=>
      active_chan == ser_chan_reg)
    else $error("serial mode channel wrong");
  // Checked against the constants, not the helper function
  khz_map_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    ce |=> tune_khz == BASE_KHZ
      + 19'($past(tune_index)) * STEP_KHZ)
    else $error("tuned frequency does not match index");
  bad_cmd_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    exec && cmd.kind == K_NONE |=> $stable(ser_chan_reg)
      && $stable(parallel_sel) && $stable(hop_active))
    else $error("bad command changed state");
  slash_clear_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    got && cmd_mode && ch == CH_SLASH |=> len_reg == 4'h0)
    else $error("slash did not clear the buffer");
  lf_skip_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    got && cmd_mode && ch == CH_LF |=> $stable(len_reg))
    else $error("line feed entered the buffer");

  unlock_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    !cmd_mode ##1 cmd_mode);
  go_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    exec && cmd.kind == K_GO);
  hop_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    exec && cmd.kind == K_HOP);
  load_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    exec && cmd.kind == K_LOAD);

endmodule

// file: include/cci_pkg.sv
// Constants and types shared by the channel command interpreter
// Notes on behaviour
// - Inverted 2400 baud serial on select bit 0
// - Eight data bits, no parity, one or two stops
// - Commands ignored until sixteen-character unlock string
// - Hash or power loss leaves command mode
// - Select pins are true logic, open reads one
// - Parallel mode reaches only channels 16 to 31
// - Unconnected select pins give channel 31
// - Channels 0 to 15 only by serial select
// - Serial select activates channel and stores it
// - Temporary tune to index 0-69, not stored
// - Temporary tune ends on reset or mode commands
// - Table assign writes index into channel entry
// - Parallel mode: pins low, fifth bit high
// - Serial mode uses last serially selected channel
// - Frequency is 433.05 MHz plus index times 25 kHz
// - Factory table: 433.9 and 433.875 MHz, 50 kHz
package cci_pkg;

  // ****************************************************************
  // Timing and sizes
  // ****************************************************************
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned BAUD       = 2400;
  localparam int unsigned BIT_CYC    = CLK_HZ / BAUD;
  localparam int unsigned UNLOCK_LEN = 16;
  localparam int unsigned CHANS      = 32;
  localparam int unsigned LINE_MAX   = 12;
  localparam int unsigned CMD_W      = 48;

  // ****************************************************************
  // Characters and command words
  // ****************************************************************
  localparam logic [127:0] UNLOCK_STR =
    128'h454e41424c4553455249414c4d4f4445;
  localparam logic [47:0] CMD_GO    = 48'h474f4348414e;
  localparam logic [47:0] CMD_HOP   = 48'h484f50504552;
  localparam logic [31:0] CMD_LOAD  = 32'h4c4f4144;
  localparam logic [47:0] CMD_PAR   = 48'h534554504152;
  localparam logic [47:0] CMD_SER   = 48'h534554534552;
  localparam logic [7:0]  CH_CR     = 8'h0d;
  localparam logic [7:0]  CH_LF     = 8'h0a;
  localparam logic [7:0]  CH_SP     = 8'h20;
  localparam logic [7:0]  CH_SLASH  = 8'h2f;
  localparam logic [7:0]  CH_HASH   = 8'h23;
  localparam logic [7:0]  CH_ZERO   = 8'h30;
  localparam logic [7:0]  CH_NINE   = 8'h39;

  // ****************************************************************
  // Channel and frequency values
  // ****************************************************************
  localparam logic [6:0]  CHAN_LAST   = 7'h1f;
  localparam logic [6:0]  IDX_MAX     = 7'h45;
  localparam logic        PAR_TOP_BIT = 1'h1;
  localparam logic [4:0]  SER_CHAN_RST = 5'h1f;
  localparam logic [6:0]  FAC_HI_BASE = 7'h22;
  localparam logic [6:0]  FAC_LO_BASE = 7'h21;
  localparam logic [18:0] BASE_KHZ    = 19'h69b9a;
  localparam logic [18:0] STEP_KHZ    = 19'h00019;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [5:0] {
    K_NONE = 6'h01,
    K_GO   = 6'h02,
    K_HOP  = 6'h04,
    K_LOAD = 6'h08,
    K_PAR  = 6'h10,
    K_SER  = 6'h20
  } cci_kind_e;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } cci_rx_e;

  typedef struct packed {
    cci_kind_e  kind;
    logic [4:0] chan;
    logic [6:0] idx;
  } cci_cmd_s;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } cci_char_s;

endpackage

// file: core/cci_uart_rx.sv
// Serial character receiver for the shared select bit 0 pin
`timescale 1ns/1ns
module cci_uart_rx import cci_pkg::*; #(
  parameter int unsigned BIT_CYC = cci_pkg::BIT_CYC
) (
  input  wire logic core_clk, // System clock
  input  wire logic arst_n,   // Asynchronous reset, active low
  input  wire logic ce,       // Clock enable
  input  wire logic line_in,  // Pin level, inverted polarity
  output cci_char_s char_out  // Byte with one-cycle valid
);
  localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYC / 2 - 1);

  cci_rx_e     state_reg;
  logic [15:0] cnt_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  shift_reg;
  logic        rx;

  assign rx = ~line_in;

  // ****************************************************************
  // Bit timing and framing
  // ****************************************************************
  // A second stop bit simply looks like idle line
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= RX_IDLE;
      cnt_reg   <= 16'h0000;
      bit_reg   <= 3'h0;
      shift_reg <= 8'h00;
      char_out  <= '0;
    end else if (ce) begin
      char_out.valid <= 1'b0;
      unique case (state_reg)
        RX_IDLE: if (!rx) begin
          state_reg <= RX_START;
          cnt_reg   <= HALF;
        end
        RX_START: if (cnt_reg == 16'h0000) begin
          // Glitch shorter than half a bit is not a start
          state_reg <= rx ? RX_IDLE : RX_DATA;
          cnt_reg   <= FULL;
          bit_reg   <= 3'h0;
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
        RX_DATA: if (cnt_reg == 16'h0000) begin
          shift_reg <= {rx, shift_reg[7:1]};
          cnt_reg   <= FULL;
          bit_reg   <= bit_reg + 3'h1;
          if (bit_reg == 3'h7) state_reg <= RX_STOP;
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
        RX_STOP: if (cnt_reg == 16'h0000) begin
          state_reg <= RX_IDLE;
          if (rx) begin
            char_out.data  <= shift_reg;
            char_out.valid <= 1'b1;
          end
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
        default: state_reg <= RX_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  frame_error_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    ce && state_reg == RX_STOP && cnt_reg == 16'h0000 && !rx
    |=> !char_out.valid)
    else $error("byte delivered despite bad stop bit");
  char_rx_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    char_out.valid);

endmodule

// file: testbench/cci_host_model.sv
// Host model: inverted asynchronous serial sender for the select pin
`timescale 1ns/1ns
module cci_host_model #(
  parameter int unsigned BIT_CYC = 16
) (
  input  wire logic       core_clk, // Bench clock
  input  wire logic       arst_n,   // Reset, active low
  input  wire logic [7:0] tx_byte,  // Character to send
  input  wire logic       tx_go,    // Send request
  input  wire logic       two_stop, // Two stop bits when high
  output logic            tx_busy,  // Frame in progress
  output logic            line_out  // Inverted serial line
);
  logic [10:0] frame_reg;
  logic [3:0]  bit_reg;
  logic [3:0]  last_reg;
  int          cyc_reg;

  // Idle and stop low, start high, data inverted and sent LSB first
  assign line_out = tx_busy & frame_reg[bit_reg];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_busy  <= 1'b0;
      bit_reg  <= 4'h0;
      cyc_reg  <= 0;
    end else if (!tx_busy) begin
      if (tx_go) begin
        frame_reg <= {2'b00, ~tx_byte, 1'b1};
        last_reg  <= two_stop ? 4'ha : 4'h9;
        bit_reg   <= 4'h0;
        cyc_reg   <= 0;
        tx_busy   <= 1'b1;
      end
    end else if (cyc_reg == BIT_CYC - 1) begin
      cyc_reg <= 0;
      if (bit_reg == last_reg) begin
        tx_busy <= 1'b0;
      end else begin
        bit_reg <= bit_reg + 4'h1;
      end
    end else begin
      cyc_reg <= cyc_reg + 1;
    end
  end
endmodule

// file: testbench/cci_channel_interp_tb_top.sv
// Self-checking bench for the channel command interpreter
`timescale 1ns/1ns
module cci_channel_interp_tb_top import cci_pkg::*;;
  localparam int unsigned BC = 16;
  // Short stand-in for the host's programming pause between lines
  localparam int GAP = 4 * BC;
  logic        core_clk = 1'b0;
  logic        arst_n   = 1'b0;
  logic        ce       = 1'b1;
  logic [3:0]  pins     = 4'hf;
  logic [7:0]  tx_byte  = 8'h00;
  logic        tx_go    = 1'b0;
  logic        two_stop = 1'b0;
  logic        sending  = 1'b0;
  logic        tx_busy;
  logic        line_out;
  logic [4:0]  active_chan;
  logic [6:0]  tune_index;
  logic [18:0] tune_khz;
  logic        cmd_mode;
  logic        hop_active;
  logic        parallel_sel;
  logic        nv_write;
  int          fails = 0;
  int          samples_checked = 0;
  int          nv_cnt = 0;
  int          tab[32];
  int          e_chan, e_hidx, e_idx, e_nv, seed_val;
  bit          e_par, e_hop, e_mode;

  cci_channel_interp #(.BIT_CYC(BC)) dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .ce(ce),
    .chan_sel_bit0_prog_in(sending ? line_out : pins[0]),
    .chan_sel_bit1(pins[1]), .chan_sel_bit2(pins[2]),
    .chan_sel_bit3(pins[3]), .active_chan(active_chan),
    .tune_index(tune_index), .tune_khz(tune_khz), .cmd_mode(cmd_mode),
    .hop_active(hop_active), .parallel_sel(parallel_sel),
    .nv_write(nv_write));

  cci_host_model #(.BIT_CYC(BC)) host_u (
    .core_clk(core_clk), .arst_n(arst_n), .tx_byte(tx_byte),
    .tx_go(tx_go), .two_stop(two_stop), .tx_busy(tx_busy),
    .line_out(line_out));

  initial forever #50 core_clk = ~core_clk;

  always @(posedge core_clk) if (nv_write === 1'b1) nv_cnt++;

  task automatic chk(input string nm, input logic [18:0] ex, got);
    samples_checked++;
    if (ex !== got) begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", nm, ex, got);
    end
  endtask

  task automatic check_all;
    // Mid-cycle look keeps clear of the edge that moves outputs and nv_cnt
    @(negedge core_clk);
    e_idx = e_hop ? e_hidx : tab[e_chan];
    chk("active_chan", 19'(e_chan), 19'(active_chan));
    chk("tune_index", 19'(e_idx), 19'(tune_index));
    chk("tune_khz", 19'(433050 + 25 * e_idx), tune_khz);
    chk("cmd_mode", 19'(e_mode), 19'(cmd_mode));
    chk("hop_active", 19'(e_hop), 19'(hop_active));
    chk("parallel_sel", 19'(e_par), 19'(parallel_sel));
    chk("nv_write count", 19'(e_nv), 19'(nv_cnt));
  endtask

  task automatic send_ch(input logic [7:0] b);
    @(posedge core_clk);
    sending  <= 1'b1;
    tx_byte  <= b;
    two_stop <= 1'($urandom_range(1));
    tx_go    <= 1'b1;
    @(posedge core_clk);
    tx_go <= 1'b0;
    for (int i = 0; i < BC * 12; i++) begin
      @(posedge core_clk);
      if (tx_busy !== 1'b1) break;
    end
  endtask

  // Line is prefix, lowest nw bytes of w sent high byte first, argument text, optional CR
  task automatic send_cmd(input string pre, input logic [127:0] w,
                          input int nw, input string arg, input bit cr);
    foreach (pre[i]) send_ch(pre[i]);
    for (int i = nw - 1; i >= 0; i--) send_ch(w[i*8 +: 8]);
    foreach (arg[i]) send_ch(arg[i]);
    if (cr) send_ch(CH_CR);
    repeat (GAP) @(posedge core_clk);
    @(posedge core_clk);
    sending <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic summarize;
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    summarize();
  end

  initial begin
    seed_val = $urandom(32'h99fb251f);
    for (int c = 0; c < 32; c++) tab[c] = c < 16 ? 33 + 2 * c : 2 + 2 * c;
    e_chan = 31; e_par = 1; e_hop = 0; e_mode = 0; e_nv = 0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    check_all();
    @(posedge core_clk);
    ce   <= 1'b0;
    pins <= 4'h0;
    repeat (6) @(posedge core_clk);
    check_all();
    @(posedge core_clk);
    ce <= 1'b1;
    repeat (20 * BC) @(posedge core_clk);
    e_chan = 16;
    send_cmd("", 128'(CMD_GO), 6, " 05", 1);
    check_all();
    send_cmd("", UNLOCK_STR, 16, "", 0);
    e_mode = 1;
    check_all();
    send_cmd("", 128'(CMD_GO), 6, " 05", 1);
    e_chan = 5; e_par = 0; e_nv++;
    check_all();
    send_cmd("", 128'(CMD_LOAD), 4, " 05 07", 1);
    tab[5] = 7; e_nv++;
    check_all();
    send_cmd("", 128'(CMD_HOP), 6, " 69", 1);
    e_hop = 1; e_hidx = 69;
    check_all();
    send_cmd("", 128'(CMD_SER), 6, "\n", 1);
    e_hop = 0; e_nv++;
    check_all();
    send_cmd("", 128'(CMD_GO), 6, " 32", 1);
    check_all();
    send_cmd("X/", 128'(CMD_GO), 6, " 03", 1);
    e_chan = 3; e_nv++;
    check_all();
    send_cmd("#", 128'(CMD_GO), 6, " 01", 1);
    e_mode = 0;
    check_all();
    send_cmd("", UNLOCK_STR, 16, "", 0);
    send_cmd("", 128'(CMD_PAR), 6, "", 1);
    e_mode = 1; e_par = 1; e_chan = 16; e_nv++;
    check_all();
    for (int k = 0; k < 6; k++) begin
      @(posedge core_clk);
      pins <= 4'($urandom_range(15));
      repeat (6) @(posedge core_clk);
      e_chan = 16 + int'(pins);
      check_all();
    end
    @(posedge core_clk);
    pins <= 4'h0;
    repeat (20 * BC) @(posedge core_clk);
    // Slash drops any byte that the pin toggling left in the line
    send_cmd("/", 128'(CMD_HOP), 6, " 20", 1);
    e_chan = 16; e_hop = 1; e_hidx = 20;
    check_all();
    @(posedge core_clk);
    pins   <= 4'hf;
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    tab[5] = 33 + 10;
    e_chan = 31; e_hop = 0; e_mode = 0;
    check_all();
    summarize();
  end
endmodule
